// File: logic/dgm_defs.svh
// Offsets, field positions, reset values and timing counts of the pin mapper
`ifndef DGM_DEFS_SVH
`define DGM_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DGM_OFS_PIN_STATUS    8'h0E
`define DGM_OFS_INPUT_DIS     8'h0F
`define DGM_OFS_PIN_CTL_FIRST 8'h10
`define DGM_OFS_PIN_CTL_LAST  8'h17
`define DGM_OFS_PORT_PAGE     8'h4C
`define DGM_OFS_BC_MAP_LOW    8'h6E
`define DGM_OFS_BC_MAP_HIGH   8'h6F
`define DGM_OFS_PULLDOWN_DIS  8'hBE

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DGM_CTL_OUT_EN        0
`define DGM_CTL_OUT_VAL       1
`define DGM_CTL_SRC_LSB       2
`define DGM_CTL_FWD_LSB       4
`define DGM_OPEN_DRAIN_PIN    3
`define DGM_SLOT_FSYNC_INT    4'h8
`define DGM_SLOT_FSYNC_EXT    4'h9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DGM_RST_INPUT_DIS     8'h00
`define DGM_RST_PULLDOWN_DIS  8'h00
`define DGM_RST_PIN_CTL       8'h00
`define DGM_RST_BC_MAP        8'h00
`define DGM_RST_PAGE          2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DGM_CLK_PERIOD_NS     25
`define DGM_FWD_LATENCY_NS    225
`define DGM_FWD_LAT_CYCLES    (`DGM_FWD_LATENCY_NS / `DGM_CLK_PERIOD_NS)
`define DGM_BC_FAST_NS        600
`define DGM_BC_SLOW_NS        12000
`define DGM_BC_FAST_CYCLES    (`DGM_BC_FAST_NS / `DGM_CLK_PERIOD_NS)
`define DGM_BC_SLOW_CYCLES    (`DGM_BC_SLOW_NS / `DGM_CLK_PERIOD_NS)
`define DGM_FWD_PERIOD_ONE    3'h1
`define DGM_FWD_PERIOD_TWO    3'h2
`define DGM_FWD_PERIOD_MANY   3'h5

`endif

// File: logic/dgm_gpio_mapper.sv
// Eight-pin general-purpose mapper with forward and back channel slots
//
// How it works
// - eight pins, each with own control register
// - all pins come up as inputs
// - pin three lacks input and pulldown disables
// - reset enables every input path and pulldown
// - bit n of input disable register disables pin n
// - status register shows every pin level
// - control bit 0 enables pin output
// - four forward values per receive port
// - any forward value drives any output pin
// - forward update every 1, 2 or 5 frames
// - fixed 225 ns forward latency
// - any pin may output frame sync
// - four back slots per port, any pin
// - one pin may feed several slots
// - back slots sampled once per back frame
// - internal or external frame sync into slots
// - slot maps in two per-port registers
`timescale 1ns/1ps
`default_nettype none
`include "dgm_defs.svh"

module dgm_gpio_mapper #(
    parameter int NUM_PINS  = 8,
    parameter int NUM_PORTS = 4
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Register access
    input  wire dgm_pkg::dgm_reg_req_type reg_req,
    output var  dgm_pkg::dgm_reg_rsp_type reg_rsp,
    // Forward channel and frame sync
    input  wire dgm_pkg::dgm_fwd_type     fwd,
    input  wire logic                     frame_sync_pulse,
    input  wire logic                     ext_frame_sync,
    input  wire logic                     bc_rate_slow,
    // Pins
    input  wire logic [7:0]               pin_in,
    output var  dgm_pkg::dgm_pad_type     pad,
    // Back channel slots per port
    output logic [3:0][3:0]               bc_slot_bits
);

    localparam int LAT = `DGM_FWD_LAT_CYCLES;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_PINS != 8 || NUM_PORTS != 4) begin : g_bad_size
        $error("dgm_gpio_mapper serves exactly 8 pins and 4 ports");
    end
    if (LAT < 2) begin : g_bad_lat
        $error("dgm_gpio_mapper needs a latency of two cycles or more");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           in_s1;
        logic [7:0]           in_s2;
        logic                 ext_s1;
        logic                 ext_s2;
        logic [7:0]           in_dis;
        logic [7:0]           pd_dis;
        logic [7:0][7:0]      pin_ctl;
        logic [3:0][7:0]      bc_lo;
        logic [3:0][7:0]      bc_hi;
        logic [1:0]           page;
        logic [3:0][3:0]      fwd_hold;
        logic [3:0][2:0]      fwd_cnt;
        logic [LAT-2:0][15:0] fwd_pipe;
        logic [8:0]           bc_div;
        logic [3:0][3:0]      bc_slot;
        dgm_pkg::dgm_pad_type pad;
        dgm_pkg::dgm_reg_rsp_type rsp;
    } dgm_state_type;

    dgm_state_type st_ff;
    dgm_state_type nxt_st;

    // Working values of the next-state process
    logic [7:0]          lvl;
    logic [15:0]         fwd_vis;
    logic [2:0]          period;
    logic [3:0]          sel;
    logic [3:0]          ofs;
    logic                drive;
    logic                bc_tick;
    logic [8:0]          bc_top;
    dgm_pkg::dgm_src_type src;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st  = st_ff;
        lvl     = '0;
        fwd_vis = '0;
        period  = '0;
        sel     = '0;
        ofs     = '0;
        drive   = 1'b0;
        src     = dgm_pkg::DGM_SRC_REG;

        // Two-stage pin synchronisers
        nxt_st.in_s1  = pin_in;
        nxt_st.in_s2  = st_ff.in_s1;
        nxt_st.ext_s1 = ext_frame_sync;
        nxt_st.ext_s2 = st_ff.ext_s1;

        // Pin level seen by the slots, gated by the input path
        lvl = st_ff.in_s2 & ~st_ff.in_dis;

        // Register writes
        if (reg_req.wr) begin
            if (reg_req.addr == `DGM_OFS_INPUT_DIS) begin
                nxt_st.in_dis = reg_req.wdata;
                nxt_st.in_dis[`DGM_OPEN_DRAIN_PIN] = 1'b0;
            end
            if (reg_req.addr == `DGM_OFS_PULLDOWN_DIS) begin
                nxt_st.pd_dis = reg_req.wdata;
                nxt_st.pd_dis[`DGM_OPEN_DRAIN_PIN] = 1'b0;
            end
            if (reg_req.addr >= `DGM_OFS_PIN_CTL_FIRST &&
                reg_req.addr <= `DGM_OFS_PIN_CTL_LAST) begin
                ofs = 4'(reg_req.addr - `DGM_OFS_PIN_CTL_FIRST);
                nxt_st.pin_ctl[ofs[2:0]] = reg_req.wdata;
            end
            if (reg_req.addr == `DGM_OFS_PORT_PAGE) begin
                nxt_st.page = reg_req.wdata[1:0];
            end
            if (reg_req.addr == `DGM_OFS_BC_MAP_LOW) begin
                nxt_st.bc_lo[st_ff.page] = reg_req.wdata;
            end
            if (reg_req.addr == `DGM_OFS_BC_MAP_HIGH) begin
                nxt_st.bc_hi[st_ff.page] = reg_req.wdata;
            end
        end

        // Register reads, answered one cycle later
        nxt_st.rsp.valid = reg_req.rd;
        nxt_st.rsp.data  = '0;
        if (reg_req.rd) begin
            if (reg_req.addr == `DGM_OFS_PIN_STATUS) begin
                nxt_st.rsp.data = st_ff.in_s2;
            end
            if (reg_req.addr == `DGM_OFS_INPUT_DIS) begin
                nxt_st.rsp.data = st_ff.in_dis;
            end
            if (reg_req.addr == `DGM_OFS_PULLDOWN_DIS) begin
                nxt_st.rsp.data = st_ff.pd_dis;
            end
            if (reg_req.addr >= `DGM_OFS_PIN_CTL_FIRST &&
                reg_req.addr <= `DGM_OFS_PIN_CTL_LAST) begin
                ofs = 4'(reg_req.addr - `DGM_OFS_PIN_CTL_FIRST);
                nxt_st.rsp.data = st_ff.pin_ctl[ofs[2:0]];
            end
            if (reg_req.addr == `DGM_OFS_PORT_PAGE) begin
                nxt_st.rsp.data = {6'h0_0, st_ff.page};
            end
            if (reg_req.addr == `DGM_OFS_BC_MAP_LOW) begin
                nxt_st.rsp.data = st_ff.bc_lo[st_ff.page];
            end
            if (reg_req.addr == `DGM_OFS_BC_MAP_HIGH) begin
                nxt_st.rsp.data = st_ff.bc_hi[st_ff.page];
            end
        end

        // Forward capture: period set by the number of linked values
        for (int p = 0; p < 4; p++) begin
            unique case (fwd.linked_count[p])
                3'h1:           period = `DGM_FWD_PERIOD_ONE;
                3'h2:           period = `DGM_FWD_PERIOD_TWO;
                3'h3, 3'h4:     period = `DGM_FWD_PERIOD_MANY;
                default:        period = 3'h0;
            endcase
            if (period == 3'h0) begin
                nxt_st.fwd_cnt[p] = '0;
            end else if (fwd.frame_tick[p]) begin
                if (st_ff.fwd_cnt[p] >= period - 3'h1) begin
                    nxt_st.fwd_cnt[p]  = '0;
                    nxt_st.fwd_hold[p] = fwd.values[p];
                end else begin
                    nxt_st.fwd_cnt[p] = st_ff.fwd_cnt[p] + 3'h1;
                end
            end
        end

        // Fixed delay line so latency does not depend on the count
        nxt_st.fwd_pipe[0] = st_ff.fwd_hold;
        for (int i = 1; i < LAT - 1; i++) begin
            nxt_st.fwd_pipe[i] = st_ff.fwd_pipe[i-1];
        end
        fwd_vis = st_ff.fwd_pipe[LAT-2];

        // Pin outputs
        for (int n = 0; n < 8; n++) begin
            src = dgm_pkg::dgm_src_type'(
                st_ff.pin_ctl[n][`DGM_CTL_SRC_LSB +: 2]);
            sel = st_ff.pin_ctl[n][`DGM_CTL_FWD_LSB +: 4];
            unique case (src)
                dgm_pkg::DGM_SRC_REG:
                    drive = st_ff.pin_ctl[n][`DGM_CTL_OUT_VAL];
                dgm_pkg::DGM_SRC_FWD:
                    drive = fwd_vis[sel];
                dgm_pkg::DGM_SRC_FSYNC:
                    drive = frame_sync_pulse;
                dgm_pkg::DGM_SRC_NONE:
                    drive = 1'b0;
            endcase
            if (n == `DGM_OPEN_DRAIN_PIN) begin
                // Open drain: only ever pulls low
                nxt_st.pad.out[n] = 1'b0;
                nxt_st.pad.oe[n]  = st_ff.pin_ctl[n][`DGM_CTL_OUT_EN]
                                    & ~drive;
            end else begin
                nxt_st.pad.out[n] = drive;
                nxt_st.pad.oe[n]  =
                    st_ff.pin_ctl[n][`DGM_CTL_OUT_EN];
            end
        end
        nxt_st.pad.input_en    = ~st_ff.in_dis;
        nxt_st.pad.pulldown_en = ~st_ff.pd_dis;

        // Back frame divider
        bc_top  = bc_rate_slow ? 9'(`DGM_BC_SLOW_CYCLES - 1)
                               : 9'(`DGM_BC_FAST_CYCLES - 1);
        bc_tick = (st_ff.bc_div >= bc_top);
        nxt_st.bc_div = bc_tick ? 9'h0_00 : st_ff.bc_div + 9'h0_01;

        // Back slots sampled once per back frame
        if (bc_tick) begin
            for (int p = 0; p < 4; p++) begin
                for (int s = 0; s < 4; s++) begin
                    sel = (s < 2) ? st_ff.bc_lo[p][(s % 2) * 4 +: 4]
                                  : st_ff.bc_hi[p][(s % 2) * 4 +: 4];
                    if (sel < 4'h8) begin
                        nxt_st.bc_slot[p][s] = lvl[sel[2:0]];
                    end else if (sel == `DGM_SLOT_FSYNC_INT) begin
                        nxt_st.bc_slot[p][s] = frame_sync_pulse;
                    end else if (sel == `DGM_SLOT_FSYNC_EXT) begin
                        nxt_st.bc_slot[p][s] = st_ff.ext_s2;
                    end else begin
                        nxt_st.bc_slot[p][s] = 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff                 <= '0;
            st_ff.in_dis          <= `DGM_RST_INPUT_DIS;
            st_ff.pd_dis          <= `DGM_RST_PULLDOWN_DIS;
            st_ff.pin_ctl         <= {8{`DGM_RST_PIN_CTL}};
            st_ff.bc_lo           <= {4{`DGM_RST_BC_MAP}};
            st_ff.bc_hi           <= {4{`DGM_RST_BC_MAP}};
            st_ff.page            <= `DGM_RST_PAGE;
            st_ff.pad.input_en    <= 8'hFF;
            st_ff.pad.pulldown_en <= 8'hFF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rsp      = st_ff.rsp;
    assign pad          = st_ff.pad;
    assign bc_slot_bits = st_ff.bc_slot;

endmodule : dgm_gpio_mapper
`default_nettype wire

// File: logic/dgm_pkg.sv
// Types shared by the pin mapper and its bench
`include "dgm_defs.svh"
package dgm_pkg;

    // Output source selection of a pin
    typedef enum logic [1:0] {
        DGM_SRC_REG,
        DGM_SRC_FWD,
        DGM_SRC_FSYNC,
        DGM_SRC_NONE
    } dgm_src_type;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dgm_reg_req_type;

    // Register read answer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dgm_reg_rsp_type;

    // Forward channel values of the four receive ports
    typedef struct packed {
        logic [3:0]      frame_tick;
        logic [3:0][2:0] linked_count;
        logic [3:0][3:0] values;
    } dgm_fwd_type;

    // Pad controls of the eight pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] input_en;
        logic [7:0] pulldown_en;
    } dgm_pad_type;

endpackage : dgm_pkg

// File: verification/dgm_gpio_mapper_properties.sv
// Port-level assertions of the pin mapper
`timescale 1ns/1ps
`default_nettype none
module dgm_gpio_mapper_chk (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // Register access
    input wire dgm_pkg::dgm_reg_req_type reg_req,
    input wire dgm_pkg::dgm_reg_rsp_type reg_rsp,
    // Channels
    input wire dgm_pkg::dgm_fwd_type     fwd,
    input wire logic                     frame_sync_pulse,
    input wire logic                     ext_frame_sync,
    input wire logic                     bc_rate_slow,
    // Pins and slots
    input wire logic [7:0]               pin_in,
    input wire dgm_pkg::dgm_pad_type     pad,
    input wire logic [3:0][3:0]          bc_slot_bits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0]     gap_ff;
    logic            seen_ff;
    logic [3:0][3:0] last_ff;
    logic            slow_ff;
    // Cycles since the last slot change, restarted on a rate change
    always_ff @(posedge clk) begin
        last_ff <= bc_slot_bits;
        slow_ff <= bc_rate_slow;
        if (!rst_n || bc_rate_slow != slow_ff) begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b0;
        end else if (bc_slot_bits != last_ff) begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b1;
        end else begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    // Status read with settled pins
    sequence status_read_s;
        $stable(pin_in) [*4] ##0 (reg_req.rd && reg_req.addr == 8'h0E);
    endsequence
    read_answer_a: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read without answer");
    quiet_bus_a: assert property (!reg_req.rd |=> !reg_rsp.valid && reg_rsp.data == 8'h00)
        else $error("answer without read");
    reset_state_a: assert property (disable iff (1'b0) !rst_n |=> pad.oe == 8'h00 && pad.input_en == 8'hFF && pad.pulldown_en == 8'hFF)
        else $error("pins not inputs after reset");
    status_read_a: assert property (status_read_s |=> reg_rsp.data == $past(pin_in))
        else $error("status differs from pin levels");
    input_dis_a: assert property ($changed(pad.input_en) |-> $past(reg_req.wr && reg_req.addr == 8'h0F, 2))
        else $error("input enable changed without write");
    oe_write_a: assert property ($changed({pad.oe[7:4], pad.oe[2:0]}) |-> $past(reg_req.wr && reg_req.addr[7:3] == 5'h02, 2))
        else $error("output enable changed without write");
    pin3_fixed_a: assert property (pad.out[3] == 1'b0 && pad.input_en[3] && pad.pulldown_en[3])
        else $error("pin three controls moved");
    slot_period_a: assert property (seen_ff && bc_rate_slow == slow_ff && bc_slot_bits != last_ff |-> (32'(gap_ff) + 1) % (bc_rate_slow ? 480 : 24) == 0)
        else $error("slots changed off back frame");
endmodule : dgm_gpio_mapper_chk
bind dgm_gpio_mapper dgm_gpio_mapper_chk i_dgm_gpio_mapper_chk (.clk, .rst_n,
    .reg_req, .reg_rsp, .fwd, .frame_sync_pulse, .ext_frame_sync,
    .bc_rate_slow, .pin_in, .pad, .bc_slot_bits);
`default_nettype wire

// File: verification/dgm_remote_model.sv
// Remote serializer model feeding forward channel frames
`timescale 1ns/1ps
`default_nettype none
module dgm_remote_model #(
    parameter int FRAME = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Link setup and remote pin levels
    input  wire logic [3:0][2:0]      linked,
    input  wire logic [3:0][3:0]      remote_lvl,
    // Forward channel
    output var  dgm_pkg::dgm_fwd_type fwd
);
    int cnt;
    // One tick per frame; values are inverted between ticks
    always @(posedge clk) begin
        cnt = (!rst_n || cnt == FRAME - 1) ? 0 : cnt + 1;
        fwd.frame_tick   <= {4{cnt == FRAME - 1}};
        fwd.linked_count <= linked;
        fwd.values       <= (cnt == FRAME - 1) ? remote_lvl : ~remote_lvl;
    end
endmodule : dgm_remote_model
`default_nettype wire

// File: verification/test_dgm_gpio_mapper.sv
// Self-checking bench of the pin mapper
`timescale 1ns/1ps
`default_nettype none
module test_dgm_gpio_mapper;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    dgm_pkg::dgm_reg_req_type reg_req = '0;
    dgm_pkg::dgm_reg_rsp_type reg_rsp;
    dgm_pkg::dgm_fwd_type     fwd;
    dgm_pkg::dgm_pad_type     pad;
    logic [3:0][3:0]          bc_slot_bits;
    logic [3:0][3:0]          remote_lvl = '0;
    logic [3:0][2:0]          linked = '0;
    logic [7:0]               ext_lvl = '0;
    logic [7:0]               pin_in;
    logic                     fsync = 1'b0;
    logic                     ext_fs = 1'b0;
    logic                     bc_slow = 1'b0;
    int                       error_cnt = 0;
    int                       n_checks = 0;
    int                       per, n, mdl[int];
    logic [7:0]               regs[15] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
        8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h4C, 8'h6E, 8'h6F, 8'hBE, 8'h20};
    always #12.5 clk = ~clk;
    // Wire level from pad drive and outside drivers
    assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_lvl);
    dgm_gpio_mapper i_dgm_gpio_mapper (.clk, .rst_n, .reg_req, .reg_rsp, .fwd,
        .frame_sync_pulse(fsync), .ext_frame_sync(ext_fs),
        .bc_rate_slow(bc_slow), .pin_in, .pad, .bc_slot_bits);
    dgm_remote_model i_dgm_remote_model (.clk, .rst_n, .linked, .remote_lvl,
        .fwd);
    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Model key, slot maps kept per page
    function automatic int key(logic [7:0] a);
        return (a inside {8'h6E, 8'h6F}) ? a + 256 * mdl[8'h4C] : a;
    endfunction : key
    task automatic wr(logic [7:0] a, logic [7:0] d);
        int k;
        k = key(a);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(negedge clk);
        reg_req.wr = 1'b0;
        @(negedge clk);
        if (a == 8'h0F || a == 8'hBE) d[3] = 1'b0;
        if (a == 8'h4C) d = d & 8'h03;
        if (mdl.exists(k)) mdl[k] = d;
    endtask : wr
    task automatic rd(logic [7:0] a);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(negedge clk);
        reg_req.rd = 1'b0;
        chk("read valid", 1, reg_rsp.valid);
        chk(a == 8'h0E ? "pin status" : "register", a == 8'h0E ? pin_in :
            mdl.exists(key(a)) ? 32'(mdl[key(a)]) : 0, reg_rsp.data);
        @(negedge clk);
    endtask : rd
    task automatic wait_pin(int p, logic v, int lim);
        for (n = 0; n < lim && pad.out[p] !== v; n++) @(negedge clk);
        if (n == lim) begin
            error_cnt++;
            close_out();
        end
    endtask : wait_pin
    // Main sequence
    initial begin
        void'($urandom(32'h9f9c_1282));
        foreach (regs[i]) if (!(regs[i] inside {8'h0E, 8'h20})) mdl[regs[i]] = 0;
        for (int p = 1; p < 4; p++) begin
            mdl[8'h6E + 256 * p] = 0;
            mdl[8'h6F + 256 * p] = 0;
        end
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        foreach (regs[i]) rd(regs[i]);
        chk("pad reset", 32'h0000_FFFF, pad);
        // Back slots of port one: pin five twice, both syncs
        ext_lvl = 8'h20;
        fsync = 1'b1;
        wr(8'h4C, 8'h01);
        wr(8'h6E, 8'h85);
        wr(8'h6F, 8'h59);
        repeat (60) @(negedge clk);
        chk("slots", 32'h0000_00B0, bc_slot_bits);
        ext_fs = 1'b1;
        wr(8'h0F, 8'h27);
        repeat (60) @(negedge clk);
        chk("slots gated", 32'h0000_0060, bc_slot_bits);
        chk("input enable", 32'h0000_00D8, pad.input_en);
        rd(8'h0E);
        // Slow back frame: no slot update for far more than 24 cycles
        bc_slow = 1'b1;
        ext_fs = 1'b0;
        repeat (100) @(negedge clk);
        chk("slots slow hold", 32'h0000_0060, bc_slot_bits);
        repeat (420) @(negedge clk);
        chk("slots slow", 32'h0000_0020, bc_slot_bits);
        bc_slow = 1'b0;
        // Register, open drain and frame sync outputs
        ext_lvl = 8'h08;
        wr(8'h10, 8'h03);
        wr(8'h13, 8'h01);
        wr(8'h12, 8'h09);
        repeat (4) @(negedge clk);
        chk("drive", 32'h0000_00D5, {pad.oe[3:0], pad.out[3:0]});
        fsync = 1'b0;
        @(negedge clk);
        chk("sync out", 0, pad.out[2]);
        // Forward value of port two, slot three, to pin one
        wr(8'h11, 8'hB5);
        for (int c = 1; c <= 4; c++) begin
            linked[2] = 3'(c);
            per = c == 1 ? 1 : c == 2 ? 2 : 5;
            repeat (2) begin
                remote_lvl[2][3] = ~remote_lvl[2][3];
                wait_pin(1, remote_lvl[2][3], 8 * per + 14);
                chk("fwd delay", 1, n >= 9 && n <= 8 * per + 12);
            end
        end
        // Random contents, unmapped and read-only places included
        ext_lvl = 8'($urandom);
        foreach (regs[i]) wr(regs[i], regs[i] == 8'h0F ?
            8'($urandom) | 8'hF7 : 8'($urandom));
        repeat (60) @(negedge clk);
        foreach (regs[i]) rd(regs[i]);
        close_out();
    end
endmodule : test_dgm_gpio_mapper
`default_nettype wire
